// ### shared/hqd_regs.vh
/*
 * Register offsets, reset values and reaction codes of the halt and
 * quick stop deceleration selector.
 * Assumes a parameter access port that presents one 16-bit word per
 * access at the parameter's own address.
 */
// Summary of operation
// - halt reaction code 1 selects velocity ramp, 3 selects torque ramp.
// - halt on velocity ramp uses the velocity profile deceleration setting.
// - halt on torque ramp uses the halt current limit.
// - reaction code writes are refused while a deceleration ramp runs.
// - new reaction codes and halt current limit act at once.
// - halt current limit is lowest of halt, motor and stage maximum.
// - during halt the I2t reduction limit is applied on top.
// - halt current limit is stored unclipped by motor or stage ratings.
// - halt current limit is unsigned 16-bit, 0.01 A rms per step.
// - halt current limit defaults to stage maximum at 8 kHz nominal mains.
// - quick stop starts on error class 1 or 2 or fieldbus command.
// - code -2: torque ramp, then operating state 9 Fault.
// - code -1: quick stop decel ramp, then operating state 9 Fault.
// - code 6: quick stop decel ramp, then stay in state 7.
// - code 7: torque ramp, then stay in state 7.
// - quick stop decel ramp uses the dedicated quick stop ramp rate.
// - quick stop torque ramp uses the quick stop current limit.
// - halt only interrupts motion; motion resumes once halt withdrawn.
`ifndef HQD_REGS_VH
`define HQD_REGS_VH

`define HQD_ADDR_HALT_REACT 16'h062E
`define HQD_ADDR_QSTOP_REACT 16'h0630
`define HQD_ADDR_HALT_ILIM 16'h111C

`define HQD_RST_HALT_REACT 16'h0001
`define HQD_RST_QSTOP_REACT 16'h0006

`define HQD_HALT_DECEL 16'h0001
`define HQD_HALT_TORQUE 16'h0003
`define HQD_QS_TORQUE_FAULT 16'hFFFE
`define HQD_QS_DECEL_FAULT 16'hFFFF
`define HQD_QS_DECEL_QSA 16'h0006
`define HQD_QS_TORQUE_QSA 16'h0007

`define HQD_OPSTATE_QSA 4'h7
`define HQD_OPSTATE_FAULT 4'h9

`endif

// ### src/hqd_halt_quickstop_ctrl.v
/*
 * Stop reaction selector: picks the deceleration source and current limit
 * for a halt or a quick stop, and the operating state after a quick stop.
 * Assumes a synchronous parameter port on i_mclk, a profile generator that
 * executes the chosen ramp and reports standstill, and a separate
 * operating-state machine that consumes the follow-on state request.
 */
`include "hqd_regs.vh"

module hqd_halt_quickstop_ctrl #(
    parameter [15:0] STAGE_MAX_DEFAULT = 16'h0000
) (
    // clock and reset
    input wire i_mclk,
    input wire i_sys_rst,
    // parameter access port
    input wire i_par_wr,
    input wire i_par_rd,
    input wire [15:0] i_par_addr,
    input wire [15:0] i_par_wdata,
    output reg [15:0] o_par_rdata,
    output reg o_par_ack,
    output reg o_par_err,
    // stop requests, asynchronous sources
    input wire i_halt_req,
    input wire i_fieldbus_qstop,
    input wire [1:0] i_error_class,
    input wire i_error_valid,
    // motion feedback
    input wire i_standstill,
    // settings from neighbouring blocks
    input wire [31:0] i_profile_decel,
    input wire [31:0] i_quickstop_decel_rate,
    input wire [15:0] i_quickstop_current_limit,
    input wire [15:0] i_motor_max_current,
    input wire [15:0] i_stage_max_current,
    input wire [15:0] i_i2t_limit,
    // stop reaction outputs
    output reg o_ramp_active,
    output reg o_use_torque_ramp,
    output reg [31:0] o_decel_rate,
    output reg [15:0] o_current_limit,
    output reg o_motion_hold,
    output reg o_opstate_req,
    output reg [3:0] o_opstate
);

    localparam ST_IDLE = 2'h0;
    localparam ST_HALT = 2'h1;
    localparam ST_QSTOP = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [15:0] halt_reaction_code;
    reg [15:0] quickstop_reaction_code;
    reg [15:0] halt_current_limit;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [15:0] qs_code_latched;

    // two-stage synchronisers for external request lines
    reg [3:0] sync1;
    reg [3:0] sync2;
    wire halt_s = sync2[0];
    wire fbqs_s = sync2[1];
    wire err_s = sync2[2];
    wire still_s = sync2[3];
    reg [1:0] ecls1;
    reg [1:0] ecls2;

    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            ecls1 <= 2'h0;
            ecls2 <= 2'h0;
        end else begin
            sync1 <= {i_standstill, i_error_valid, i_fieldbus_qstop, i_halt_req};
            sync2 <= sync1;
            ecls1 <= i_error_class;
            ecls2 <= ecls1;
        end
    end

    wire qs_trigger = fbqs_s | (err_s & ((ecls2 == 2'h1) | (ecls2 == 2'h2)));
    wire ramping = (state == ST_HALT) | (state == ST_QSTOP);

    wire halt_code_ok = (i_par_wdata == `HQD_HALT_DECEL) | (i_par_wdata == `HQD_HALT_TORQUE);
    wire qs_code_ok = (i_par_wdata == `HQD_QS_TORQUE_FAULT) | (i_par_wdata == `HQD_QS_DECEL_FAULT) |
                      (i_par_wdata == `HQD_QS_DECEL_QSA) | (i_par_wdata == `HQD_QS_TORQUE_QSA);
    wire hit_halt = (i_par_addr == `HQD_ADDR_HALT_REACT);
    wire hit_qs = (i_par_addr == `HQD_ADDR_QSTOP_REACT);
    wire hit_ilim = (i_par_addr == `HQD_ADDR_HALT_ILIM);
    wire hit_any = hit_halt | hit_qs | hit_ilim;

    // write acceptance, one flag per parameter
    wire halt_wr_ok = i_par_wr & hit_halt & ~ramping & halt_code_ok;
    wire qs_wr_ok = i_par_wr & hit_qs & ~ramping & qs_code_ok;
    wire ilim_wr_ok = i_par_wr & hit_ilim;

    reg next_par_err;
    reg [15:0] next_par_rdata;

    // parameter port: single-cycle answer, refused writes flag an error
    always @* begin
        next_par_err = 1'b0;
        next_par_rdata = o_par_rdata;
        if (i_par_wr) begin
            // refused or unmapped writes leave every setting untouched
            next_par_err = ~(halt_wr_ok | qs_wr_ok | ilim_wr_ok);
        end else if (i_par_rd) begin
            next_par_err = ~hit_any;
            if (hit_halt) begin
                next_par_rdata = halt_reaction_code;
            end else if (hit_qs) begin
                next_par_rdata = quickstop_reaction_code;
            end else if (hit_ilim) begin
                next_par_rdata = halt_current_limit;
            end else begin
                next_par_rdata = 16'h0000;
            end
        end
    end

    // answer strobe and read data
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_par_ack <= 1'b0;
            o_par_err <= 1'b0;
            o_par_rdata <= 16'h0000;
        end else begin
            o_par_ack <= i_par_wr | i_par_rd;
            o_par_err <= next_par_err;
            o_par_rdata <= next_par_rdata;
        end
    end

    // halt code is read live by the stop logic, so a write acts at once
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            halt_reaction_code <= `HQD_RST_HALT_REACT;
        end else if (halt_wr_ok) begin
            halt_reaction_code <= i_par_wdata;
        end
    end

    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quickstop_reaction_code <= `HQD_RST_QSTOP_REACT;
        end else if (qs_wr_ok) begin
            quickstop_reaction_code <= i_par_wdata;
        end
    end

    // full 16-bit range stored, never clipped to motor or stage ratings;
    // the default is strapped so readback matches the value in use
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            halt_current_limit <= STAGE_MAX_DEFAULT;
        end else if (ilim_wr_ok) begin
            halt_current_limit <= i_par_wdata;
        end
    end

    // state machine: quick stop outranks halt
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (qs_trigger) begin
                    next_state = ST_QSTOP;
                end else if (halt_s) begin
                    next_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (qs_trigger) begin
                    next_state = ST_QSTOP;
                end else if (!halt_s) begin
                    next_state = ST_IDLE;
                end
            end
            ST_QSTOP: begin
                if (still_s) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // leaving needs the quick stop cause to clear
                if (!qs_trigger) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // the entry cycle must see the fresh code, not the one latched last time
    wire qs_entry = (state != ST_QSTOP) & (next_state == ST_QSTOP);
    wire [15:0] qs_code_sel = qs_entry ? quickstop_reaction_code : qs_code_latched;
    wire qs_torque = (qs_code_sel == `HQD_QS_TORQUE_FAULT) | (qs_code_sel == `HQD_QS_TORQUE_QSA);
    wire qs_fault = (qs_code_sel == `HQD_QS_TORQUE_FAULT) | (qs_code_sel == `HQD_QS_DECEL_FAULT);
    wire halt_torque = (halt_reaction_code == `HQD_HALT_TORQUE);

    function [15:0] min16;
        input [15:0] a;
        input [15:0] b;
        begin
            min16 = (a < b) ? a : b;
        end
    endfunction

    wire [15:0] halt_lim3 = min16(min16(halt_current_limit, i_motor_max_current), i_stage_max_current);
    wire [15:0] halt_lim = min16(halt_lim3, i_i2t_limit);
    wire [15:0] qs_lim3 = min16(min16(i_quickstop_current_limit, i_motor_max_current), i_stage_max_current);
    wire [15:0] qs_lim = min16(qs_lim3, i_i2t_limit);
    wire [15:0] run_lim = min16(min16(i_motor_max_current, i_stage_max_current), i_i2t_limit);

    reg next_ramp_active;
    reg next_motion_hold;
    reg next_use_torque_ramp;
    reg [31:0] next_decel_rate;
    reg [15:0] next_current_limit;
    reg next_opstate_req;
    reg [3:0] next_opstate;
    reg [15:0] next_qs_code;

    // next values of the stop outputs
    always @* begin
        next_ramp_active = (next_state == ST_HALT) | (next_state == ST_QSTOP);
        next_motion_hold = (next_state != ST_IDLE);
        next_use_torque_ramp = 1'b0;
        next_decel_rate = i_profile_decel;
        next_current_limit = run_lim;
        next_opstate_req = 1'b0;
        next_opstate = o_opstate;
        next_qs_code = qs_code_latched;
        // frozen at entry; writes are refused while ramping anyway
        if (qs_entry) begin
            next_qs_code = quickstop_reaction_code;
        end
        // halt settings are read live so rewrites act at once
        if (next_state == ST_HALT) begin
            next_use_torque_ramp = halt_torque;
            next_decel_rate = i_profile_decel;
            next_current_limit = halt_torque ? halt_lim : run_lim;
        end else if (next_state == ST_QSTOP) begin
            next_use_torque_ramp = qs_torque;
            next_decel_rate = i_quickstop_decel_rate;
            next_current_limit = qs_torque ? qs_lim : run_lim;
        end
        if (state == ST_QSTOP && next_state == ST_DONE) begin
            next_opstate_req = 1'b1;
            next_opstate = qs_fault ? `HQD_OPSTATE_FAULT : `HQD_OPSTATE_QSA;
        end
    end

    // state and the reaction code in force for this quick stop
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            qs_code_latched <= `HQD_RST_QSTOP_REACT;
        end else begin
            state <= next_state;
            qs_code_latched <= next_qs_code;
        end
    end

    // ramp and hold flags
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_ramp_active <= 1'b0;
            o_motion_hold <= 1'b0;
        end else begin
            o_ramp_active <= next_ramp_active;
            o_motion_hold <= next_motion_hold;
        end
    end

    // ramp type, rate and current limit handed to the profile generator
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_use_torque_ramp <= 1'b0;
            o_decel_rate <= 32'h00000000;
            o_current_limit <= 16'h0000;
        end else begin
            o_use_torque_ramp <= next_use_torque_ramp;
            o_decel_rate <= next_decel_rate;
            o_current_limit <= next_current_limit;
        end
    end

    // follow-on state request; the state value is held after the pulse
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_opstate_req <= 1'b0;
            o_opstate <= 4'h0;
        end else begin
            o_opstate_req <= next_opstate_req;
            o_opstate <= next_opstate;
        end
    end

endmodule // hqd_halt_quickstop_ctrl

// ### verif/hqd_stop_chk.sv
/* Port checker for the stop reaction selector.
   Assumes stop inputs are held steady while each stop runs. */
module hqd_stop_chk (
    input wire i_mclk, i_sys_rst, i_par_wr, i_par_rd, i_halt_req, i_fieldbus_qstop,
    input wire i_error_valid, i_standstill, o_par_ack, o_par_err, o_ramp_active,
    input wire o_use_torque_ramp, o_motion_hold, o_opstate_req,
    input wire [15:0] i_par_addr, i_par_wdata, o_current_limit, i_quickstop_current_limit,
    input wire [15:0] i_motor_max_current, i_stage_max_current, i_i2t_limit,
    input wire [31:0] i_profile_decel, i_quickstop_decel_rate, o_decel_rate,
    input wire [3:0] o_opstate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    wire code_wr = i_par_wr && (i_par_addr == 16'h062E || i_par_addr == 16'h0630);
    wire [15:0] m1 = i_motor_max_current < i_stage_max_current ? i_motor_max_current : i_stage_max_current;
    wire [15:0] m2 = m1 < i_i2t_limit ? m1 : i_i2t_limit;
    wire [15:0] qs_lim = m2 < i_quickstop_current_limit ? m2 : i_quickstop_current_limit;
    ack_follows_a: assert property ((i_par_wr || i_par_rd) |=> o_par_ack) else $error("no ack");
    ack_alone_a: assert property (!(i_par_wr || i_par_rd) |=> !o_par_ack && !o_par_err) else $error("stray ack");
    ramp_refuse_a: assert property (code_wr && o_ramp_active |=> o_par_err) else $error("write in ramp");
    bad_halt_a: assert property (i_par_wr && i_par_addr == 16'h062E && i_par_wdata != 16'h0001
        && i_par_wdata != 16'h0003 |=> o_par_err) else $error("bad code taken");
    qs_start_a: assert property ($rose(i_fieldbus_qstop) && !o_motion_hold && !i_standstill
        |-> ##3 o_ramp_active) else $error("stop late");
    halt_rate_a: assert property (o_ramp_active && !o_use_torque_ramp && $past(i_halt_req, 4)
        && !$past(i_fieldbus_qstop, 4) && !$past(i_error_valid, 4)
        |-> o_decel_rate == i_profile_decel) else $error("halt rate");
    qs_rate_a: assert property (o_ramp_active && !o_use_torque_ramp && $past(i_fieldbus_qstop, 4)
        |-> o_decel_rate == i_quickstop_decel_rate) else $error("stop rate");
    qs_torque_a: assert property (o_ramp_active && o_use_torque_ramp && $past(i_fieldbus_qstop, 4)
        |-> o_current_limit == qs_lim) else $error("stop limit");
    qs_end_a: assert property (o_opstate_req |-> !o_ramp_active && (o_opstate == 4'h7
        || o_opstate == 4'h9) ##1 !o_opstate_req) else $error("end state");
    halt_free_a: assert property ($fell(i_halt_req) && !i_fieldbus_qstop && !i_error_valid
        |-> ##[2:4] !o_motion_hold) else $error("no resume");
    cover property (o_ramp_active && o_use_torque_ramp);
    cover property (o_opstate_req && o_opstate == 4'h9);
    cover property (o_par_err);
endmodule // hqd_stop_chk

bind hqd_halt_quickstop_ctrl hqd_stop_chk u_hqd_stop_chk (.*);

// ### verif/hqd_drive_model.sv
/* Motor side model: comes to rest some cycles into a stop ramp.
   Assumes ramp and hold levels arrive on the same clock. */
module hqd_drive_model (
    input wire i_mclk,
    input wire i_slow,
    input wire i_ramp_active,
    input wire i_motion_hold,
    output reg o_standstill
);
    timeunit 1ns;
    timeprecision 1ns;
    integer cnt = 0;
    initial o_standstill = 1'b0;
    // a heavy load stretches the ramp
    always @(posedge i_mclk) begin
        if (!i_motion_hold) begin
            cnt <= 0;
            o_standstill <= 1'b0;
        end else if (i_ramp_active) begin
            cnt <= cnt + 1;
            o_standstill <= cnt >= (i_slow ? 40 : 5);
        end
    end
endmodule // hqd_drive_model

// ### verif/halt_quickstop_decel_control_tb.sv
/* Self-checking bench for the stop reaction selector.
   Assumes the parameter port answers one cycle after each strobe. */
module halt_quickstop_decel_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    reg i_mclk = 1'b0, i_sys_rst = 1'b1, i_par_wr = 1'b0, i_par_rd = 1'b0, slow = 1'b0;
    reg i_halt_req = 1'b0, i_fieldbus_qstop = 1'b0, i_error_valid = 1'b0;
    reg [1:0] i_error_class = 2'h0;
    reg [15:0] i_par_addr = 16'h0000, i_par_wdata = 16'h0000, i_quickstop_current_limit = 16'h0150;
    reg [15:0] i_motor_max_current = 16'h0200, i_stage_max_current = 16'h0300, i_i2t_limit = 16'h0400;
    reg [31:0] i_profile_decel = 32'h0000_0258, i_quickstop_decel_rate = 32'h0000_1770;
    reg [15:0] qc [0:3] = '{16'hFFFE, 16'hFFFF, 16'h0006, 16'h0007};
    wire [15:0] o_par_rdata, o_current_limit;
    wire [31:0] o_decel_rate;
    wire [3:0] o_opstate;
    wire o_par_ack, o_par_err, o_ramp_active, o_use_torque_ramp, o_motion_hold, o_opstate_req, i_standstill;
    integer failures = 0, samples_checked = 0, i, n;
    always #5 i_mclk = ~i_mclk;
    hqd_halt_quickstop_ctrl #(.STAGE_MAX_DEFAULT(16'h0300)) u_hqd_halt_quickstop_ctrl (.*);
    hqd_drive_model u_hqd_drive_model (.i_mclk(i_mclk), .i_slow(slow), .i_ramp_active(o_ramp_active),
        .i_motion_hold(o_motion_hold), .o_standstill(i_standstill));
    task check(input [31:0] got, exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    task acc(input w, input [15:0] a, d, input e, input [15:0] r);
        begin
            @(posedge i_mclk);
            i_par_wr <= w;
            i_par_rd <= !w;
            i_par_addr <= a;
            i_par_wdata <= d;
            @(posedge i_mclk);
            i_par_wr <= 1'b0;
            i_par_rd <= 1'b0;
            #1;
            check({o_par_ack, o_par_err, w ? 16'h0000 : o_par_rdata}, {1'b1, e, r});
        end
    endtask
    task wr(input [15:0] a, d, input e);
        acc(1'b1, a, d, e, 16'h0000);
    endtask
    task rd(input [15:0] a, r, input e);
        acc(1'b0, a, 16'h0000, e, r);
    endtask
    // bounded wait on ramp (0), state request (1) or hold (2)
    task wt(input integer s, input v);
        begin
            n = 0;
            while ((s == 0 ? o_ramp_active : s == 1 ? o_opstate_req : o_motion_hold) !== v) begin
                @(posedge i_mclk);
                #1;
                n = n + 1;
                if (n > 300) begin
                    failures = failures + 1;
                    tally_and_finish;
                end
            end
        end
    endtask
    task settle;
        begin
            repeat (4) @(posedge i_mclk);
            #1;
        end
    endtask
    initial begin
        repeat (3) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        rd(16'h062E, 16'h0001, 1'b0);
        rd(16'h111C, 16'h0300, 1'b0);
        rd(16'h0630, 16'h0006, 1'b0);
        rd(16'h0200, 16'h0000, 1'b1);
        wr(16'h062E, 16'h0002, 1'b1);
        wr(16'h0630, 16'h0005, 1'b1);
        rd(16'h0630, 16'h0006, 1'b0);
        wr(16'h111C, 16'hFFFF, 1'b0);
        rd(16'h111C, 16'hFFFF, 1'b0);
        wr(16'h111C, 16'h0123, 1'b0);
        $display("registers done");
        for (i = 0; i < 2; i = i + 1) begin
            wr(16'h062E, i ? 16'h0003 : 16'h0001, 1'b0);
            @(posedge i_mclk);
            i_halt_req <= 1'b1;
            wt(0, 1'b1);
            check(o_use_torque_ramp, i);
            check(i ? o_current_limit : o_decel_rate, i ? 16'h0123 : i_profile_decel);
            wr(16'h062E, i ? 16'h0001 : 16'h0003, 1'b1);
            wr(16'h0630, 16'h0007, 1'b1);
            if (i) begin
                wr(16'h111C, 16'h0250, 1'b0);
                settle;
                check(o_current_limit, 16'h0200);
                i_stage_max_current <= 16'h0180;
                settle;
                check(o_current_limit, 16'h0180);
                i_i2t_limit <= 16'h0080;
                settle;
                check(o_current_limit, 16'h0080);
                i_i2t_limit <= 16'h0400;
            end
            @(posedge i_mclk);
            i_halt_req <= 1'b0;
            wt(2, 1'b0);
            repeat (4) @(posedge i_mclk);
            $display("halt %0d done", i);
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr(16'h0630, qc[i], 1'b0);
            @(posedge i_mclk);
            slow <= i[1];
            i_error_class <= {i[1], ~i[1]};
            i_error_valid <= i[0];
            i_fieldbus_qstop <= !i[0];
            wt(0, 1'b1);
            check(o_use_torque_ramp, i == 0 || i == 3);
            check(o_use_torque_ramp ? o_current_limit : o_decel_rate,
                o_use_torque_ramp ? 16'h0150 : i_quickstop_decel_rate);
            wr(16'h0630, 16'h0006, 1'b1);
            wt(1, 1'b1);
            check(o_opstate, i < 2 ? 4'h9 : 4'h7);
            @(posedge i_mclk);
            i_error_valid <= 1'b0;
            i_fieldbus_qstop <= 1'b0;
            wt(2, 1'b0);
            repeat (4) @(posedge i_mclk);
            $display("quick stop %0d done", i);
        end
        i_error_class <= 2'h3;
        i_error_valid <= 1'b1;
        repeat (10) @(posedge i_mclk);
        #1;
        check(o_ramp_active, 1'b0);
        tally_and_finish;
    end
endmodule // halt_quickstop_decel_control_tb
